// ### hw/ftr_fifo.v
/*
  512 x 36 fifo with programmable almost-empty / almost-full flags,
  synchronous retransmit and an axi4-lite register slave.
  assumes every input is synchronous to i_clk; write and read sides
  are separate logical domains joined by gray pointer crossings.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ftr_fifo_map.vh"

module ftr_fifo (
  // clock and reset
  input  wire                       i_clk,
  input  wire                       i_reset_n,
  // offset load mode and serial load
  input  wire [1:0]                 i_flag_sel,
  input  wire                       i_serial_en,
  input  wire                       i_serial_data,
  // write port
  input  wire                       i_wr_en,
  input  wire [`FTR_DATA_W-1:0]     i_wr_data,
  output wire                       o_input_room,
  output wire                       o_almost_full_n,
  // read port
  input  wire                       i_rd_en,
  output wire [`FTR_DATA_W-1:0]     o_rd_data,
  output wire                       o_output_valid,
  output wire                       o_almost_empty_n,
  // retransmit control
  input  wire                       i_replay_mode_in,
  input  wire                       i_replay_restart_in,
  // axi4-lite write address
  input  wire [`FTR_AXI_AW-1:0]     s_axi_awaddr,
  input  wire                       s_axi_awvalid,
  output wire                       s_axi_awready,
  // axi4-lite write data
  input  wire [31:0]                s_axi_wdata,
  input  wire [3:0]                 s_axi_wstrb,
  input  wire                       s_axi_wvalid,
  output wire                       s_axi_wready,
  // axi4-lite write response
  output wire [1:0]                 s_axi_bresp,
  output wire                       s_axi_bvalid,
  input  wire                       s_axi_bready,
  // axi4-lite read address
  input  wire [`FTR_AXI_AW-1:0]     s_axi_araddr,
  input  wire                       s_axi_arvalid,
  output wire                       s_axi_arready,
  // axi4-lite read data
  output wire [31:0]                s_axi_rdata,
  output wire [1:0]                 s_axi_rresp,
  output wire                       s_axi_rvalid,
  input  wire                       s_axi_rready
);
  // storage and pointers
  reg  [`FTR_DATA_W-1:0] mem [0:(1<<`FTR_ADDR_W)-1];
  reg  [`FTR_PTR_W-1:0]  wptr_reg;
  reg  [`FTR_PTR_W-1:0]  rptr_reg;
  reg  [`FTR_PTR_W-1:0]  shadow_reg;
  reg  [`FTR_DATA_W-1:0] out_reg;
  reg                    ovalid_reg;
  reg                    rtm_reg;
  reg  [1:0]             rpl_cnt_reg;

  // crossed pointers and fill levels
  wire [`FTR_PTR_W-1:0]  wptr_rd;
  wire [`FTR_PTR_W-1:0]  rptr_src;
  wire [`FTR_PTR_W-1:0]  rptr_wr;
  wire [`FTR_PTR_W-1:0]  fill_rd;
  wire [`FTR_PTR_W-1:0]  fill_wr;
  wire [`FTR_DEPTH-`FTR_DEPTH+10:0] af_sum;

  // offsets
  wire [`FTR_OFS_W-1:0]  low_ofs;
  wire [`FTR_OFS_W-1:0]  high_ofs;
  wire                   ofs_done;
  wire                   sw_low_we;
  wire                   sw_high_we;

  // port control
  wire                   room;
  wire                   wr_go;
  wire                   rd_has;
  wire                   shift_out;
  wire                   rtm_enter;
  wire                   rtm_exit;
  wire                   restart;

  // bus slave state
  reg                    aw_have_reg;
  reg  [`FTR_AXI_AW-1:0] aw_addr_reg;
  reg                    w_have_reg;
  reg  [31:0]            w_data_reg;
  reg  [3:0]             w_strb_reg;
  reg                    bvalid_reg;
  reg  [1:0]             bresp_reg;
  reg                    rvalid_reg;
  reg  [31:0]            rdata_reg;
  reg  [1:0]             rresp_reg;
  wire                   bus_wr;
  wire                   wr_hit;
  reg  [31:0]            rd_word;
  reg                    rd_hit;

  // ------------------------------------------------------------
  // offset registers
  // ------------------------------------------------------------
  ftr_ofs_load u_ofs_load (
    .i_clk        (i_clk),
    .i_reset_n    (i_reset_n),
    .i_sel        (i_flag_sel),
    .i_ser_en     (i_serial_en),
    .i_ser_bit    (i_serial_data),
    .i_par_en     (i_wr_en),
    .i_par_data   (i_wr_data[`FTR_OFS_W-1:0]),
    .i_sw_low_we  (sw_low_we),
    .i_sw_high_we (sw_high_we),
    .i_sw_data    (w_data_reg[`FTR_OFS_W-1:0]),
    .o_low        (low_ofs),
    .o_high       (high_ofs),
    .o_done       (ofs_done)
  );

  // ------------------------------------------------------------
  // pointer crossings
  // ------------------------------------------------------------
  // write side follows the shadow while replaying
  assign rptr_src = rtm_reg ? shadow_reg : rptr_reg;

  // two flops each way give the two-edge flag latency
  ftr_ptr_sync u_wptr_sync (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_ptr     (wptr_reg),
    .o_ptr     (wptr_rd)
  );

  ftr_ptr_sync u_rptr_sync (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_ptr     (rptr_src),
    .o_ptr     (rptr_wr)
  );

  // output register word already left memory
  assign fill_rd = wptr_rd - rptr_reg;
  assign fill_wr = wptr_reg - rptr_wr;

  // ------------------------------------------------------------
  // write side
  // ------------------------------------------------------------
  // full when the pointer distance reaches depth
  assign room  = ofs_done && !fill_wr[`FTR_PTR_W-1];
  assign wr_go = i_wr_en && room;

  always @(posedge i_clk) begin
    if (wr_go)
      mem[wptr_reg[`FTR_ADDR_W-1:0]] <= i_wr_data;
  end

  always @(posedge i_clk) begin
    if (!i_reset_n)
      wptr_reg <= {`FTR_PTR_W{1'b0}};
    else if (wr_go)
      wptr_reg <= wptr_reg + `FTR_ONE_PTR;
  end

  // fill + high offset below depth
  assign af_sum = {1'b0, fill_wr} + {2'b00, high_ofs};

  assign o_input_room    = room;
  assign o_almost_full_n = ofs_done && (af_sum < `FTR_DEPTH);

  // ------------------------------------------------------------
  // read side
  // ------------------------------------------------------------
  assign rd_has    = (fill_rd != {`FTR_PTR_W{1'b0}});
  // reads only count while a word is valid
  assign shift_out = !ovalid_reg || i_rd_en;

  // replay mode entry and exit
  assign rtm_enter = !rtm_reg && i_replay_mode_in && ovalid_reg;
  assign rtm_exit  = rtm_reg && !i_replay_mode_in;
  // restart needs two reads past the first replay word
  // an earlier restart request is ignored
  assign restart   = rtm_reg && i_replay_mode_in &&
                     i_replay_restart_in &&
                     (rpl_cnt_reg == `FTR_RPL_MIN);

  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      rptr_reg   <= {`FTR_PTR_W{1'b0}};
      out_reg    <= {`FTR_DATA_W{1'b0}};
      ovalid_reg <= 1'b0;
    end else if (restart) begin
      // shadow word reloaded, valid at once
      out_reg    <= mem[shadow_reg[`FTR_ADDR_W-1:0]];
      rptr_reg   <= shadow_reg + `FTR_ONE_PTR;
      ovalid_reg <= 1'b1;
    end else if (shift_out) begin
      if (rd_has) begin
        out_reg    <= mem[rptr_reg[`FTR_ADDR_W-1:0]];
        rptr_reg   <= rptr_reg + `FTR_ONE_PTR;
        ovalid_reg <= 1'b1;
      end else begin
        ovalid_reg <= 1'b0;
      end
    end
  end

  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      rtm_reg     <= 1'b0;
      shadow_reg  <= {`FTR_PTR_W{1'b0}};
      rpl_cnt_reg <= 2'h0;
    end else if (rtm_enter) begin
      // mark the location of the word now in the output register
      rtm_reg     <= 1'b1;
      shadow_reg  <= rptr_reg - `FTR_ONE_PTR;
      rpl_cnt_reg <= 2'h0;
    end else if (rtm_exit) begin
      rtm_reg     <= 1'b0;
      rpl_cnt_reg <= 2'h0;
    end else if (restart) begin
      rpl_cnt_reg <= 2'h0;
    end else if (rtm_reg && shift_out && rd_has &&
                 rpl_cnt_reg != `FTR_RPL_MIN) begin
      rpl_cnt_reg <= rpl_cnt_reg + 2'h1;
    end
  end

  // compare against crossed write pointer
  assign o_almost_empty_n = (fill_rd > {1'b0, low_ofs});
  assign o_output_valid   = ovalid_reg;
  assign o_rd_data        = out_reg;

  // ------------------------------------------------------------
  // axi4-lite slave
  // ------------------------------------------------------------
  assign s_axi_awready = !aw_have_reg && !bvalid_reg;
  assign s_axi_wready  = !w_have_reg && !bvalid_reg;
  assign bus_wr        = aw_have_reg && w_have_reg && !bvalid_reg;
  assign wr_hit        = (aw_addr_reg == `FTR_REG_LOW) ||
                         (aw_addr_reg == `FTR_REG_HIGH) ||
                         (aw_addr_reg == `FTR_REG_STATUS) ||
                         (aw_addr_reg == `FTR_REG_FILL);
  // offsets take the low two byte lanes together
  assign sw_low_we     = bus_wr && (aw_addr_reg == `FTR_REG_LOW) &&
                         (&w_strb_reg[1:0]);
  assign sw_high_we    = bus_wr && (aw_addr_reg == `FTR_REG_HIGH) &&
                         (&w_strb_reg[1:0]);

  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      aw_have_reg <= 1'b0;
      aw_addr_reg <= {`FTR_AXI_AW{1'b0}};
      w_have_reg  <= 1'b0;
      w_data_reg  <= 32'h00000000;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `FTR_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= {s_axi_awaddr[`FTR_AXI_AW-1:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (bus_wr) begin
        aw_have_reg <= 1'b0;
        w_have_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_hit ? `FTR_RESP_OKAY : `FTR_RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always @* begin
    rd_word = 32'h00000000;
    rd_hit  = 1'b1;
    case ({s_axi_araddr[`FTR_AXI_AW-1:2], 2'b00})
      `FTR_REG_LOW:  rd_word[`FTR_OFS_W-1:0] = low_ofs;
      `FTR_REG_HIGH: rd_word[`FTR_OFS_W-1:0] = high_ofs;
      `FTR_REG_STATUS: begin
        rd_word[`FTR_ST_OVALID] = ovalid_reg;
        rd_word[`FTR_ST_AE_N]   = o_almost_empty_n;
        rd_word[`FTR_ST_AF_N]   = o_almost_full_n;
        rd_word[`FTR_ST_ROOM]   = room;
        rd_word[`FTR_ST_DONE]   = ofs_done;
        rd_word[`FTR_ST_RTM]    = rtm_reg;
      end
      `FTR_REG_FILL: begin
        rd_word[`FTR_PTR_W-1:0]    = fill_rd;
        rd_word[`FTR_PTR_W+15:16]  = fill_wr;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  assign s_axi_arready = !rvalid_reg;

  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h00000000;
      rresp_reg  <= `FTR_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_word;
      rresp_reg  <= rd_hit ? `FTR_RESP_OKAY : `FTR_RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata  = rdata_reg;
  assign s_axi_rresp  = rresp_reg;
endmodule // ftr_fifo

`default_nettype wire

// ### hw/ftr_fifo_map.vh
/*
  constants for the threshold-flag / retransmit fifo:
  geometry, offset presets, load-mode codes, register map.
  assumes inclusion by every design file of the block.
*/
`ifndef FTR_FIFO_MAP_VH
`define FTR_FIFO_MAP_VH

// geometry: 512 x 36
`define FTR_DATA_W       36
`define FTR_ADDR_W       9
`define FTR_PTR_W        10
`define FTR_DEPTH        11'h200
`define FTR_OFS_W        9
`define FTR_ONE_PTR      10'h001

// offset presets and load modes
`define FTR_PRESET_HI    9'h040
`define FTR_PRESET_LO    9'h008
`define FTR_SEL_PAR      2'b00
`define FTR_SEL_8        2'b01
`define FTR_SEL_64       2'b10
`define FTR_SEL_SERIAL   2'b11
`define FTR_SER_BITS     5'h12

// replay read count needed before a restart
`define FTR_RPL_MIN      2'h2

// axi4-lite register map, byte addresses
`define FTR_AXI_AW       8
`define FTR_REG_LOW      8'h00
`define FTR_REG_HIGH     8'h04
`define FTR_REG_STATUS   8'h08
`define FTR_REG_FILL     8'h0c
`define FTR_RESP_OKAY    2'b00
`define FTR_RESP_SLVERR  2'b10

// status bit positions
`define FTR_ST_OVALID    0
`define FTR_ST_AE_N      1
`define FTR_ST_AF_N      2
`define FTR_ST_ROOM      3
`define FTR_ST_DONE      4
`define FTR_ST_RTM       5

`endif

// ### hw/ftr_ofs_load.v
/*
  threshold offset registers with preset, serial and write-port loading.
  assumes i_sel is stable while reset is held; software writes come
  from the bus slave in the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ftr_fifo_map.vh"

module ftr_ofs_load (
  // clock and reset
  input  wire                  i_clk,
  input  wire                  i_reset_n,
  // load mode
  input  wire [1:0]            i_sel,
  // serial load
  input  wire                  i_ser_en,
  input  wire                  i_ser_bit,
  // write-port load
  input  wire                  i_par_en,
  input  wire [`FTR_OFS_W-1:0] i_par_data,
  // software load
  input  wire                  i_sw_low_we,
  input  wire                  i_sw_high_we,
  input  wire [`FTR_OFS_W-1:0] i_sw_data,
  // offsets and completion
  output wire [`FTR_OFS_W-1:0] o_low,
  output wire [`FTR_OFS_W-1:0] o_high,
  output wire                  o_done
);
  reg [1:0]            sel_reg;
  reg [`FTR_OFS_W-1:0] low_reg;
  reg [`FTR_OFS_W-1:0] high_reg;
  reg                  done_reg;
  reg                  par_cnt_reg;
  reg [4:0]            ser_cnt_reg;

  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      sel_reg     <= i_sel;
      par_cnt_reg <= 1'b0;
      ser_cnt_reg <= 5'h00;
      // preset during reset
      case (i_sel)
        `FTR_SEL_64: begin
          low_reg  <= `FTR_PRESET_HI;
          high_reg <= `FTR_PRESET_HI;
          done_reg <= 1'b1;
        end
        `FTR_SEL_8: begin
          low_reg  <= `FTR_PRESET_LO;
          high_reg <= `FTR_PRESET_LO;
          done_reg <= 1'b1;
        end
        default: begin
          low_reg  <= {`FTR_OFS_W{1'b0}};
          high_reg <= {`FTR_OFS_W{1'b0}};
          done_reg <= 1'b0;
        end
      endcase
    end else if (!done_reg) begin
      if (sel_reg == `FTR_SEL_SERIAL && i_ser_en) begin
        // low offset first, msb first
        {low_reg, high_reg} <= {low_reg[`FTR_OFS_W-2:0], high_reg,
                                i_ser_bit};
        ser_cnt_reg <= ser_cnt_reg + 5'h01;
        if (ser_cnt_reg == `FTR_SER_BITS - 5'h01)
          done_reg <= 1'b1;
      end else if (sel_reg == `FTR_SEL_PAR && i_par_en) begin
        // first word low offset, second high
        if (!par_cnt_reg)
          low_reg <= i_par_data;
        else begin
          high_reg <= i_par_data;
          done_reg <= 1'b1;
        end
        par_cnt_reg <= 1'b1;
      end
    end else begin
      if (i_sw_low_we)
        low_reg <= i_sw_data;
      if (i_sw_high_we)
        high_reg <= i_sw_data;
    end
  end

  assign o_low  = low_reg;
  assign o_high = high_reg;
  assign o_done = done_reg;
endmodule // ftr_ofs_load

`default_nettype wire

// ### hw/ftr_ptr_sync.v
/*
  pointer crossing: binary to gray, two flops, gray back to binary.
  assumes the source pointer changes by at most one per clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ftr_fifo_map.vh"

module ftr_ptr_sync (
  // clock and reset
  input  wire                  i_clk,
  input  wire                  i_reset_n,
  // pointer in and out
  input  wire [`FTR_PTR_W-1:0] i_ptr,
  output wire [`FTR_PTR_W-1:0] o_ptr
);
  reg  [`FTR_PTR_W-1:0] meta_reg;
  reg  [`FTR_PTR_W-1:0] sync_reg;
  wire [`FTR_PTR_W-1:0] gray_in;
  wire [`FTR_PTR_W-1:0] bin_out;
  genvar              g;

  assign gray_in = i_ptr ^ (i_ptr >> 1);

  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      meta_reg <= {`FTR_PTR_W{1'b0}};
      sync_reg <= {`FTR_PTR_W{1'b0}};
    end else begin
      meta_reg <= gray_in;
      sync_reg <= meta_reg;
    end
  end

  assign bin_out[`FTR_PTR_W-1] = sync_reg[`FTR_PTR_W-1];
  generate
    for (g = 0; g < `FTR_PTR_W-1; g = g + 1) begin : g_gray2bin
      assign bin_out[g] = bin_out[g+1] ^ sync_reg[g];
    end
  endgenerate

  assign o_ptr = bin_out;
endmodule // ftr_ptr_sync

`default_nettype wire

// ### sim/ftr_fifo_props.sv
/*
  port-level checks for the threshold-flag / retransmit fifo.
  assumes a single clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ftr_fifo_map.vh"
module ftr_fifo_chk (
  // clock and reset
  input wire                   i_clk,
  input wire                   i_reset_n,
  // fifo ports
  input wire                   i_wr_en,
  input wire                   o_input_room,
  input wire                   o_almost_full_n,
  input wire                   i_rd_en,
  input wire [`FTR_DATA_W-1:0] o_rd_data,
  input wire                   o_output_valid,
  input wire                   o_almost_empty_n,
  input wire                   i_replay_mode_in,
  input wire                   i_replay_restart_in,
  // bus handshakes
  input wire                   s_axi_awvalid,
  input wire                   s_axi_awready,
  input wire                   s_axi_wvalid,
  input wire                   s_axi_wready,
  input wire                   s_axi_bvalid,
  input wire                   s_axi_arvalid,
  input wire                   s_axi_arready,
  input wire                   s_axi_rvalid
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  rd_hold_a: assert property (
    (!o_output_valid ##1 !o_output_valid) |-> $stable(o_rd_data))
    else $error("output word moved while not valid");
  valid_drop_a: assert property (
    $fell(o_output_valid) |-> $past(i_rd_en))
    else $error("output valid fell without a read");
  data_move_a: assert property (
    $changed(o_rd_data) |-> $past(i_rd_en && o_output_valid) ||
      $rose(o_output_valid) || $past(i_replay_restart_in))
    else $error("output word changed without cause");
  ae_rise_a: assert property (
    $rose(o_almost_empty_n) |-> $past(i_wr_en && o_input_room, 3) ||
      $past(i_replay_restart_in) || $past(i_replay_restart_in, 2) ||
      $past(i_replay_restart_in, 3))
    else $error("almost empty rose off the write timing");
  af_fall_a: assert property (
    $fell(o_almost_full_n) |-> $past(i_wr_en) || $past(i_replay_mode_in))
    else $error("almost full fell without a write");
  af_rise_a: assert property (
    $rose(o_almost_full_n) && $past(o_input_room) |->
      $past(i_rd_en && o_output_valid, 3))
    else $error("almost full rose off the read timing");
  room_fall_a: assert property (
    $fell(o_input_room) |-> $past(i_wr_en) || $past(i_replay_mode_in))
    else $error("input room fell without a write");
  bresp_time_a: assert property (
    (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready)
      |=> ##1 s_axi_bvalid)
    else $error("write response late");
  rresp_time_a: assert property (
    (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
    else $error("read response late");
endmodule // ftr_fifo_chk
bind ftr_fifo ftr_fifo_chk u_chk (.*);
`default_nettype wire

// ### sim/ftr_fifo_test.sv
/*
  self-checking bench for the threshold-flag / retransmit fifo.
  assumes the design map header and a write-side source model.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ftr_fifo_map.vh"
module ftr_fifo_test;
  logic        i_clk = 1'h0, i_reset_n = 1'h0, go = 1'h0;
  logic        i_serial_en = 1'h0, i_serial_data = 1'h0, i_rd_en = 1'h0;
  logic        i_replay_mode_in = 1'h0, i_replay_restart_in = 1'h0;
  logic [1:0]  i_flag_sel = `FTR_SEL_8;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
  logic        s_axi_rready = 1'h0;
  logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, d;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [1:0]  r;
  wire         i_wr_en, o_input_room, o_almost_full_n, o_output_valid;
  wire         o_almost_empty_n, s_axi_awready, s_axi_wready;
  wire         s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [35:0]  i_wr_data, o_rd_data;
  wire [31:0]  s_axi_rdata;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  integer      fails = 0, n_tests = 0, cyc = 0;

  ftr_fifo u_dut (.*);
  ftr_wr_model u_src (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_go(go),
    .i_room(o_input_room), .o_wr_en(i_wr_en), .o_wr_data(i_wr_data));

  always #2.5 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fails = fails + 1;
      end_sim;
    end
  end

  task end_sim;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task cmp(input string nm, input [35:0] e, input [35:0] s);
    n_tests = n_tests + 1;
    if (s !== e) begin
      fails = fails + 1;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task do_reset(input [1:0] s);
    @(posedge i_clk) i_reset_n <= 1'h0;
    i_flag_sel <= s;
    repeat (8) @(posedge i_clk);
    i_reset_n <= 1'h1;
  endtask
  task put(input integer n);
    @(posedge i_clk) go <= 1'h1;
    repeat (n) @(posedge i_clk);
    go <= 1'h0;
  endtask
  // compare the word on show, then take it
  task rd(input integer n, input [35:0] first);
    @(posedge i_clk) i_rd_en <= 1'h1;
    for (int k = 0; k < n; k++) begin
      do @(negedge i_clk); while (!o_output_valid);
      cmp("rd_data", first + k, o_rd_data);
      @(posedge i_clk);
    end
    i_rd_en <= 1'h0;
  endtask
  task restart;
    @(posedge i_clk) i_replay_restart_in <= 1'h1;
    @(posedge i_clk) i_replay_restart_in <= 1'h0;
    @(negedge i_clk);
  endtask
  task axi_wr(input [7:0] a, input [31:0] v);
    logic aw, w;
    aw = 1'h1;
    w = 1'h1;
    @(posedge i_clk) s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (aw || w) begin
      @(negedge i_clk);
      if (s_axi_awready) aw = 1'h0;
      if (s_axi_wready) w = 1'h0;
      @(posedge i_clk);
      if (!aw) s_axi_awvalid <= 1'h0;
      if (!w) s_axi_wvalid <= 1'h0;
    end
    do @(negedge i_clk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    @(posedge i_clk) s_axi_bready <= 1'h0;
  endtask
  task axi_rd(input [7:0] a);
    @(posedge i_clk) s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(negedge i_clk); while (!s_axi_arready);
    @(posedge i_clk) s_axi_arvalid <= 1'h0;
    do @(negedge i_clk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge i_clk) s_axi_rready <= 1'h0;
  endtask

  task t_thresh(input [1:0] s, input integer n, input e);
    do_reset(s);
    if (s == `FTR_SEL_SERIAL) begin
      // low offset 3 then high offset 5, msb first
      for (int i = 17; i >= 0; i--) begin
        @(posedge i_clk) i_serial_en <= 1'h1;
        i_serial_data <= (18'h00605 >> i) & 18'h1;
      end
      @(posedge i_clk) i_serial_en <= 1'h0;
      repeat (4) @(posedge i_clk);
    end
    else if (s == `FTR_SEL_PAR) put(2);
    put(n);
    repeat (8) @(posedge i_clk);
    cmp("ae_n", e, o_almost_empty_n);
  endtask
  task t_ae_edge;
    do_reset(`FTR_SEL_8);
    put(9);
    repeat (8) @(posedge i_clk);
    put(1);
    @(negedge i_clk) cmp("ae_n e0", 1'h0, o_almost_empty_n);
    @(negedge i_clk) cmp("ae_n e1", 1'h0, o_almost_empty_n);
    @(negedge i_clk) cmp("ae_n e2", 1'h1, o_almost_empty_n);
    rd(10, 36'h0);
    @(negedge i_clk) cmp("valid", 1'h0, o_output_valid);
  endtask
  task t_full;
    do_reset(`FTR_SEL_8);
    put(600);
    cmp("writes", 36'd513, i_wr_data);
    cmp("af_n", 1'h0, o_almost_full_n);
    cmp("room", 1'h0, o_input_room);
    rd(8, 36'h0);
    repeat (4) @(posedge i_clk);
    rd(1, 36'h8);
    @(negedge i_clk) cmp("af_n e0", 1'h0, o_almost_full_n);
    @(negedge i_clk) cmp("af_n e1", 1'h0, o_almost_full_n);
    @(negedge i_clk) cmp("af_n e2", 1'h1, o_almost_full_n);
    cmp("room", 1'h1, o_input_room);
    rd(504, 36'h9);
  endtask
  task t_replay;
    do_reset(`FTR_SEL_8);
    put(6);
    repeat (6) @(posedge i_clk);
    @(posedge i_clk) i_replay_mode_in <= 1'h1;
    rd(2, 36'h0);
    repeat (4) @(posedge i_clk);
    axi_rd(`FTR_REG_FILL);
    cmp("fill", 36'h00060003, d);
    restart;
    cmp("restart", 36'h0, o_rd_data);
    cmp("valid", 1'h1, o_output_valid);
    rd(3, 36'h0);
    restart;
    cmp("loop", 36'h0, o_rd_data);
    rd(1, 36'h0);
    restart;
    cmp("early", 36'h1, o_rd_data);
    axi_rd(`FTR_REG_STATUS);
    cmp("in mode", 1'h1, d[`FTR_ST_RTM]);
    @(posedge i_clk) i_replay_mode_in <= 1'h0;
    axi_rd(`FTR_REG_STATUS);
    cmp("out mode", 1'h0, d[`FTR_ST_RTM]);
    rd(5, 36'h1);
  endtask
  task t_axi;
    do_reset(`FTR_SEL_8);
    axi_rd(`FTR_REG_STATUS);
    cmp("status", 36'h1c, d);
    axi_rd(`FTR_REG_LOW);
    cmp("low", `FTR_PRESET_LO, d);
    axi_wr(`FTR_REG_HIGH, 32'h10);
    cmp("bresp", `FTR_RESP_OKAY, r);
    axi_rd(`FTR_REG_HIGH);
    cmp("high", 36'h10, d);
    axi_wr(`FTR_REG_STATUS, 32'h0);
    cmp("ro bresp", `FTR_RESP_OKAY, r);
    axi_rd(8'h20);
    cmp("unmapped", `FTR_RESP_SLVERR, r);
  endtask

  initial begin
    t_thresh(`FTR_SEL_8, 9, 1'h0);
    t_thresh(`FTR_SEL_8, 10, 1'h1);
    t_thresh(`FTR_SEL_64, 65, 1'h0);
    t_thresh(`FTR_SEL_64, 66, 1'h1);
    t_thresh(`FTR_SEL_SERIAL, 4, 1'h0);
    t_thresh(`FTR_SEL_SERIAL, 5, 1'h1);
    t_thresh(`FTR_SEL_PAR, 1, 1'h0);
    t_thresh(`FTR_SEL_PAR, 2, 1'h1);
    t_ae_edge;
    t_full;
    t_replay;
    t_axi;
    end_sim;
  end
endmodule // ftr_fifo_test
`default_nettype wire

// ### sim/ftr_wr_model.sv
/*
  write-side source: offers a running count while enabled.
  assumes i_go changes just after a rising clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module ftr_wr_model (
  // clock and reset
  input  wire        i_clk,
  input  wire        i_reset_n,
  // control
  input  wire        i_go,
  input  wire        i_room,
  // write port drive
  output wire        o_wr_en,
  output wire [35:0] o_wr_data
);
  reg [35:0] cnt_reg;
  assign o_wr_en   = i_go;
  assign o_wr_data = cnt_reg;
  // next word only once the fifo took this one
  always @(posedge i_clk) begin
    if (!i_reset_n) cnt_reg <= 36'h0;
    else if (i_go && i_room) cnt_reg <= cnt_reg + 36'h1;
  end
endmodule // ftr_wr_model
`default_nettype wire
